// *** verilog/frac_pkg.sv ***
// Constants and types shared by the fuse and ROM access control block
package frac_pkg;

	// ----------------------------------------------------------------
	// Fuse map
	// ----------------------------------------------------------------
	localparam int FUSE_COUNT     = 128;  // Whole fuse array
	localparam int PERMIT_FUSE    = 1;    // Single burn permit fuse
	localparam int SECRET_LAST    = 63;   // Last secret fuse
	localparam int STATUS_FIRST   = 64;   // First user status fuse
	localparam int PAUSE_FIRST    = 84;   // First long-pause fuse
	localparam int STATUS_LAST    = 86;   // Last user status fuse
	localparam int LOCK_FUSE      = 87;   // Personalization lock fuse
	localparam int MAKER_FIRST    = 88;   // Fuse maker code start
	localparam int SERIAL_FIRST   = 96;   // Fuse serial part start
	localparam int MSG_FUSES      = 88;   // Fuses carried to digest
	localparam int FIRST_RD_WORD  = 2;    // First readable fuse word

	// ----------------------------------------------------------------
	// ROM map
	// ----------------------------------------------------------------
	localparam logic [6:0] ROM_ADDR_ID  = 7'h00; // Maker code, serial
	localparam logic [6:0] ROM_ADDR_REV = 7'h01; // Revision bytes

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD    = 8'h00; // Command, write only
	localparam logic [7:0] REG_MASK   = 8'h04; // Personalization mask
	localparam logic [7:0] REG_STATUS = 8'h08; // Status flags
	localparam logic [7:0] REG_DATA   = 8'h0C; // Read result

	// ----------------------------------------------------------------
	// Command word fields
	// ----------------------------------------------------------------
	localparam int CMD_OP_LSB  = 0;  // Opcode low bit
	localparam int CMD_IDX_LSB = 8;  // Index low bit

	// ----------------------------------------------------------------
	// Status word fields
	// ----------------------------------------------------------------
	localparam int ST_DONE    = 0; // Last command accepted
	localparam int ST_REFUSED = 1; // Burn refused
	localparam int ST_ADDR    = 2; // Forbidden read address
	localparam int ST_PERMIT  = 3; // Permit fuse level
	localparam int ST_LOCK    = 4; // Lock fuse level

	// ----------------------------------------------------------------
	// Reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WORD   = 32'h0000_0000; // Register reset
	localparam logic [1:0]  RESP_OKAY  = 2'h0;          // AXI OKAY
	localparam logic [1:0]  RESP_SLERR = 2'h2;          // AXI SLVERR

	// Commands taken through the command register
	typedef enum logic [3:0] {
		OP_NONE   = 4'h0,
		OP_READ   = 4'h1,
		OP_SINGLE = 4'h3,
		OP_PERS   = 4'h2,
		OP_ROM    = 4'h6
	} frac_op_e;

endpackage : frac_pkg

// *** verilog/frac_fuse_array.sv ***
// One-time fuse array model with factory image at reset
`timescale 1ns/1ps
module frac_fuse_array
	import frac_pkg::*;
#(
	parameter logic [7:0]  FUSE_MAKER  = 8'h5A,        // Arbitrary value
	parameter logic [31:0] FUSE_SERIAL = 32'h0000_0001 // Arbitrary value
) (
	input  wire logic         sys_clk_i, // System clock
	input  wire logic         rst_n_i,   // Sync reset, active low
	input  wire logic [127:0] burn_i,    // One-cycle burn vector
	output logic      [127:0] fuse_o     // Present fuse levels
);

	// Factory image: fresh fuses one, identity bits set
	localparam logic [127:0] FACTORY = {FUSE_SERIAL, FUSE_MAKER,
		{MSG_FUSES{1'b1}}};

	// Identity region never takes a burn
	localparam logic [127:0] BURNABLE = {{(FUSE_COUNT - MSG_FUSES){1'b0}},
		{MSG_FUSES{1'b1}}};

	logic [127:0] fuse_q; // Fuse levels
	logic [127:0] fuse_d; // Next fuse levels

	// Burning only clears bits, never sets them
	always_comb begin
		fuse_d = fuse_q & ~(burn_i & BURNABLE);
	end

	// Register the array
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			fuse_q <= FACTORY;
		end else begin
			fuse_q <= fuse_d;
		end
	end

	assign fuse_o = fuse_q;

endmodule : frac_fuse_array

// *** verilog/frac_rom.sv ***
// Readable part of the mask ROM
`timescale 1ns/1ps
module frac_rom
	import frac_pkg::*;
#(
	parameter logic [15:0] ROM_MAKER  = 16'h5A3C,     // Arbitrary value
	parameter logic [15:0] ROM_SERIAL = 16'h0001,     // Arbitrary value
	parameter logic [31:0] ROM_REV    = 32'h0000_0001 // Arbitrary value
) (
	input  wire logic [6:0]  addr_i,  // ROM word address
	output logic      [31:0] data_o,  // Word, byte 0 in low bits
	output logic             ok_o     // Address is readable
);

	// Only the first two words are open to the outside
	always_comb begin
		data_o = RST_WORD;
		ok_o   = 1'b0;
		if (addr_i == ROM_ADDR_ID) begin
			data_o = {ROM_SERIAL, ROM_MAKER};
			ok_o   = 1'b1;
		end else if (addr_i == ROM_ADDR_REV) begin
			data_o = ROM_REV;
			ok_o   = 1'b1;
		end
		// Anything further stays hidden
	end

endmodule : frac_rom

// *** verilog/frac_top.sv ***
// Fuse and ROM access control with AXI4-Lite register slave
`timescale 1ns/1ps
module frac_top
	import frac_pkg::*;
#(
	parameter logic [15:0] ROM_MAKER   = 16'h5A3C,      // Arbitrary value
	parameter logic [15:0] ROM_SERIAL  = 16'h0001,      // Arbitrary value
	parameter logic [31:0] ROM_REV     = 32'h0000_0001, // Arbitrary value
	parameter logic [7:0]  FUSE_MAKER  = 8'h5A,         // Arbitrary value
	parameter logic [31:0] FUSE_SERIAL = 32'h0000_0001  // Arbitrary value
) (
	input  wire logic        sys_clk_i,     // System clock
	input  wire logic        rst_n_i,       // Sync reset, active low
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Byte enables
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read data valid
	input  wire logic        s_axi_rready,  // Read data ready
	// Toward the digest engine and pause logic
	output logic [87:0]      msg_fuse_o,    // Fuse bits for the digest
	output logic [47:0]      serial_num_o,  // Unique serial number
	output logic [2:0]       pause_fuse_o   // Long-pause fuses 84-86
);

	// ----------------------------------------------------------------
	// Internal state
	// ----------------------------------------------------------------
	logic [127:0] fuse;                     // Present fuse levels
	logic [127:0] burn_d;                   // Burn vector this cycle
	logic [31:0]  rom_data;                 // ROM lookup word
	logic         rom_ok;                   // ROM address readable
	logic         aw_held_q, aw_held_d;     // Write address captured
	logic         w_held_q, w_held_d;       // Write data captured
	logic [7:0]   awaddr_q, awaddr_d;       // Captured write address
	logic [31:0]  wdata_q, wdata_d;         // Captured write data
	logic [3:0]   wstrb_q, wstrb_d;         // Captured byte enables
	logic         bvalid_q, bvalid_d;       // Write response pending
	logic [1:0]   bresp_q, bresp_d;         // Write response code
	logic         rvalid_q, rvalid_d;       // Read data pending
	logic [1:0]   rresp_q, rresp_d;         // Read response code
	logic [31:0]  rdata_q, rdata_d;         // Read data word
	logic [31:0]  mask_q, mask_d;           // Personalization mask
	logic [31:0]  data_q, data_d;           // Command result
	logic         done_q, done_d;           // Command taken
	logic         refused_q, refused_d;     // Burn refused
	logic         addr_err_q, addr_err_d;   // Forbidden read
	logic [87:0]  msg_q, msg_d;             // Digest fuse view
	logic         do_write;                 // Both halves present
	logic         cmd_go;                   // Command write
	frac_op_e     op;                       // Decoded opcode
	logic [6:0]   idx;                      // Command index
	logic [1:0]   word;                     // Fuse word of index
	logic         permit;                   // Single burn permitted
	logic         unlocked;                 // Lock fuse still one

	// ----------------------------------------------------------------
	// Storage blocks
	// ----------------------------------------------------------------
	frac_fuse_array #(
		.FUSE_MAKER  (FUSE_MAKER),
		.FUSE_SERIAL (FUSE_SERIAL)
	) u_fuse (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.burn_i    (burn_d),
		.fuse_o    (fuse)
	);

	frac_rom #(
		.ROM_MAKER  (ROM_MAKER),
		.ROM_SERIAL (ROM_SERIAL),
		.ROM_REV    (ROM_REV)
	) u_rom (
		.addr_i (idx),
		.data_o (rom_data),
		.ok_o   (rom_ok)
	);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// A command runs once, in the cycle where both halves are held;
	// the pending answer then blocks the same word from running twice
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign cmd_go   = do_write && (awaddr_q == REG_CMD) && wstrb_q[0];
	assign op       = frac_op_e'(wdata_q[CMD_OP_LSB +: 4]);
	assign idx      = wdata_q[CMD_IDX_LSB +: 7];
	assign word     = idx[6:5];
	assign permit   = fuse[PERMIT_FUSE];
	assign unlocked = fuse[LOCK_FUSE];

	// Command execution: burn vector, result and flags
	always_comb begin
		burn_d     = '0;
		data_d     = data_q;
		done_d     = done_q;
		refused_d  = refused_q;
		addr_err_d = addr_err_q;
		if (cmd_go) begin
			done_d     = 1'b1;
			refused_d  = 1'b0;
			addr_err_d = 1'b0;
			data_d     = RST_WORD;
			case (op)
				OP_READ: begin
					if (word < 2'(FIRST_RD_WORD)) begin
						addr_err_d = 1'b1;
					end else begin
						data_d = fuse[{word, 5'h00} +: 32];
					end
				end
				OP_SINGLE: begin
					// Only status fuses, only while permitted
					if (permit && (idx >= 7'(STATUS_FIRST)) &&
						(idx <= 7'(STATUS_LAST))) begin
						burn_d[idx] = 1'b1;
					end else begin
						refused_d = 1'b1;
					end
				end
				OP_PERS: begin
					// Mask word lands on word 0..2, bits above 87 dropped
					if (unlocked && (word <= 2'(FIRST_RD_WORD))) begin
						burn_d[{word, 5'h00} +: 32] = mask_q;
					end else begin
						refused_d = 1'b1;
					end
				end
				OP_ROM: begin
					if (rom_ok) begin
						data_d = rom_data;
					end else begin
						addr_err_d = 1'b1;
					end
				end
				default: begin
					addr_err_d = 1'b1;
				end
			endcase
		end
	end

	// Digest view: forced ones until the lock fuse is burned
	// Registered so the digest sees one settled copy per cycle;
	// it lags the fuse array by one clock
	always_comb begin
		if (unlocked) begin
			msg_d = {fuse[LOCK_FUSE], {(MSG_FUSES - 1){1'b1}}};
		end else begin
			msg_d = fuse[MSG_FUSES - 1:0];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	// Readies drop while a half is held or an answer waits
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;

	// Capture address and data in either order, answer after both
	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d  = w_held_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		mask_d    = mask_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (do_write) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = RESP_OKAY;
			if (awaddr_q == REG_MASK) begin
				for (int b = 0; b < 4; b++) begin
					if (wstrb_q[b]) begin
						mask_d[8*b +: 8] = wdata_q[8*b +: 8];
					end
				end
			end else if (awaddr_q != REG_CMD) begin
				// Status, data and holes are not writable
				bresp_d = RESP_SLERR;
			end
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = !rvalid_q;

	// One read at a time, answered the cycle after the address
	always_comb begin
		rvalid_d = rvalid_q;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			rdata_d  = RST_WORD;
			if (s_axi_araddr == REG_MASK) begin
				rdata_d = mask_q;
			end else if (s_axi_araddr == REG_STATUS) begin
				rdata_d[ST_DONE]    = done_q;
				rdata_d[ST_REFUSED] = refused_q;
				rdata_d[ST_ADDR]    = addr_err_q;
				rdata_d[ST_PERMIT]  = permit;
				rdata_d[ST_LOCK]    = unlocked;
			end else if (s_axi_araddr == REG_DATA) begin
				rdata_d = data_q;
			end else if (s_axi_araddr != REG_CMD) begin
				rresp_d = RESP_SLERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset restores a fresh part: all state back to idle
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			aw_held_q  <= 1'b0;
			w_held_q   <= 1'b0;
			awaddr_q   <= '0;
			wdata_q    <= RST_WORD;
			wstrb_q    <= '0;
			bvalid_q   <= 1'b0;
			bresp_q    <= RESP_OKAY;
			rvalid_q   <= 1'b0;
			rresp_q    <= RESP_OKAY;
			rdata_q    <= RST_WORD;
			mask_q     <= RST_WORD;
			data_q     <= RST_WORD;
			done_q     <= 1'b0;
			refused_q  <= 1'b0;
			addr_err_q <= 1'b0;
			msg_q      <= {MSG_FUSES{1'b1}};
		end else begin
			aw_held_q  <= aw_held_d;
			w_held_q   <= w_held_d;
			awaddr_q   <= awaddr_d;
			wdata_q    <= wdata_d;
			wstrb_q    <= wstrb_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			rvalid_q   <= rvalid_d;
			rresp_q    <= rresp_d;
			rdata_q    <= rdata_d;
			mask_q     <= mask_d;
			data_q     <= data_d;
			done_q     <= done_d;
			refused_q  <= refused_d;
			addr_err_q <= addr_err_d;
			msg_q      <= msg_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp  = rresp_q;
	assign s_axi_rdata  = rdata_q;
	assign msg_fuse_o   = msg_q;
	assign serial_num_o = {ROM_SERIAL, fuse[SERIAL_FIRST +: 32]};
	assign pause_fuse_o = fuse[PAUSE_FIRST +: 3];

endmodule : frac_top

// *** testbench/frac_top_sva.sv ***
// Checker for bus handshakes and the digest fuse view
`timescale 1ns/1ps
module frac_top_sva
	import frac_pkg::*;
#(
	parameter logic [15:0] ROM_SERIAL  = 16'h0001,     // Arbitrary value
	parameter logic [31:0] FUSE_SERIAL = 32'h0000_0001 // Arbitrary value
) (
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [87:0] msg_fuse_o,
	input wire logic [47:0] serial_num_o,
	input wire logic [2:0]  pause_fuse_o
);
	// ----------------------------------------------------------------
	// Handshake steps and assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Both write channels taken at one edge
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Read address taken
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write answer missing");
	a_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not cleared");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_digest_masked: assert property (msg_fuse_o[87] |-> &msg_fuse_o[86:0])
		else $error("fuse view not masked");
	a_lock_stays: assert property (!msg_fuse_o[87] |=> !msg_fuse_o[87])
		else $error("lock fuse returned to one");
	a_pause_no_rise: assert property ((pause_fuse_o & ~$past(pause_fuse_o)) == 3'b000)
		else $error("pause fuse returned to one");
	a_serial_fixed: assert property (serial_num_o == {ROM_SERIAL, FUSE_SERIAL})
		else $error("serial number wrong");
endmodule : frac_top_sva

bind frac_top frac_top_sva #(.ROM_SERIAL(ROM_SERIAL),
	.FUSE_SERIAL(FUSE_SERIAL)) u_sva (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .msg_fuse_o(msg_fuse_o),
	.serial_num_o(serial_num_o), .pause_fuse_o(pause_fuse_o));

// *** testbench/frac_host.sv ***
// Register bus master standing in for the host controller
`timescale 1ns/1ps
module frac_host (
	input  wire logic        sys_clk_i,
	output logic      [7:0]  awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic      [31:0] wdata,
	output logic      [3:0]  wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic      [7:0]  araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	// Idle bus at time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wstrb} = 20'h0_0000;
		wdata = 32'h0000_0000;
	end
	// Write: both channels offered, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic aw_p, w_p, ta, tw;
		@(posedge sys_clk_i);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		aw_p = 1'b1;
		w_p = 1'b1;
		// Readies judged settled, before the edge that takes them
		while (aw_p || w_p) begin
			@(negedge sys_clk_i);
			ta = aw_p && awready;
			tw = w_p && wready;
			@(posedge sys_clk_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			aw_p = aw_p && !ta;
			w_p = w_p && !tw;
		end
		do @(negedge sys_clk_i); while (!bvalid);
		r = bresp;
		@(posedge sys_clk_i);
		bready <= 1'b0;
	endtask : wr
	// Read: rready raised late so the slave must hold its answer
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge sys_clk_i);
		araddr  <= a;
		arvalid <= 1'b1;
		do @(negedge sys_clk_i); while (!arready);
		@(posedge sys_clk_i);
		arvalid <= 1'b0;
		do @(negedge sys_clk_i); while (!rvalid);
		@(posedge sys_clk_i);
		rready <= 1'b1;
		@(negedge sys_clk_i);
		d = rdata;
		r = rresp;
		@(posedge sys_clk_i);
		rready <= 1'b0;
	endtask : rd
endmodule : frac_host

// *** testbench/frac_top_tb.sv ***
// Self-checking bench for the fuse and ROM access control block
`timescale 1ns/1ps
module frac_top_tb
	import frac_pkg::*;
;
	localparam logic [15:0] RM = 16'hA1B2;      // Arbitrary value
	localparam logic [15:0] RS = 16'hC3D4;      // Arbitrary value
	localparam logic [31:0] RV = 32'h0E0F_1011; // Arbitrary value
	localparam logic [7:0]  FM = 8'h96;         // Arbitrary value
	localparam logic [31:0] FS = 32'h8765_4321; // Arbitrary value
	logic         sys_clk_i = 1'b0;
	logic         rst_n_i;
	logic [7:0]   awaddr, araddr;
	logic [31:0]  wdata, rdata;
	logic [3:0]   wstrb;
	logic [1:0]   bresp, rresp;
	logic         awvalid, awready, wvalid, wready, bvalid, bready;
	logic         arvalid, arready, rvalid, rready;
	logic [87:0]  msg_fuse_o;
	logic [47:0]  serial_num_o;
	logic [2:0]   pause_fuse_o;
	logic [127:0] ef;            // Expected fuse levels
	logic         dn = 1'b0;     // Expected done flag
	int           err_total = 0;
	int           cmp_count = 0;

	always #4 sys_clk_i = ~sys_clk_i;

	frac_top #(.ROM_MAKER(RM), .ROM_SERIAL(RS), .ROM_REV(RV),
		.FUSE_MAKER(FM), .FUSE_SERIAL(FS)) dut (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .msg_fuse_o(msg_fuse_o),
		.serial_num_o(serial_num_o), .pause_fuse_o(pause_fuse_o));

	frac_host host (.sys_clk_i(sys_clk_i), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic [1:0] r;
		host.wr(a, d, s, r);
		chk(r, er);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		host.rd(a, d, r);
		chk(d, ed);
		chk(r, er);
	endtask : rd
	task automatic cmd(input frac_op_e op, input logic [6:0] idx);
		wr(REG_CMD, {17'h0_0000, idx, 4'h0, op}, 4'hF, RESP_OKAY);
		dn = 1'b1;
	endtask : cmd
	// Refused and address flags, then permit and lock levels
	task automatic st(input logic rf, input logic ae);
		rd(REG_STATUS, {27'h000_0000, ef[87], ef[1], ae, rf, dn}, RESP_OKAY);
	endtask : st
	task automatic fw(input logic [1:0] w, input logic ae);
		cmd(OP_READ, {w, 5'h00});
		st(1'b0, ae);
		rd(REG_DATA, ae ? 32'h0000_0000 : ef[32*w +: 32], RESP_OKAY);
	endtask : fw
	task automatic sb(input logic [6:0] idx, input logic ok);
		cmd(OP_SINGLE, idx);
		if (ok) ef[idx] = 1'b0;
		st(!ok, 1'b0);
	endtask : sb
	task automatic pb(input logic [1:0] w, input logic [31:0] m,
		input logic ok);
		wr(REG_MASK, m, 4'hF, RESP_OKAY);
		cmd(OP_PERS, {w, 5'h00});
		for (int i = 0; i < 32; i++)
			if (ok && m[i] && !(w == 2'd2 && i >= 24)) ef[32*w+i] = 1'b0;
		st(!ok, 1'b0);
	endtask : pb
	task automatic vw();
		@(negedge sys_clk_i); // Sample settled outputs
		chk(msg_fuse_o, ef[87] ? {88{1'b1}} : ef[87:0]);
		chk(pause_fuse_o, ef[86:84]);
	endtask : vw

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_id();
		st(1'b0, 1'b0);
		vw();
		chk(serial_num_o, {RS, FS});
		fw(2'd0, 1'b1);
		fw(2'd1, 1'b1);
		fw(2'd2, 1'b0);
		fw(2'd3, 1'b0);
	endtask : t_id
	task automatic t_rom();
		cmd(OP_ROM, 7'd0);
		rd(REG_DATA, {RS, RM}, RESP_OKAY);
		cmd(OP_ROM, 7'd1);
		rd(REG_DATA, RV, RESP_OKAY);
		cmd(OP_ROM, 7'd2);
		st(1'b0, 1'b1);
		rd(REG_DATA, 32'h0000_0000, RESP_OKAY);
	endtask : t_rom
	task automatic t_bus();
		rd(8'h10, 32'h0000_0000, RESP_SLERR);
		wr(8'h10, 32'h0000_0001, 4'hF, RESP_SLERR);
		wr(REG_STATUS, 32'hFFFF_FFFF, 4'hF, RESP_SLERR);
		wr(REG_MASK, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
		wr(REG_MASK, 32'h1234_5678, 4'h5, RESP_OKAY);
		rd(REG_MASK, 32'hFF34_FF78, RESP_OKAY);
		rd(REG_CMD, 32'h0000_0000, RESP_OKAY);
		cmd(OP_NONE, 7'd0);
		st(1'b0, 1'b1);
		wr(REG_CMD, {17'h0_0000, 7'd0, 4'h0, OP_ROM}, 4'hE, RESP_OKAY);
		st(1'b0, 1'b1);
	endtask : t_bus
	task automatic t_single();
		sb(7'd64, 1'b1);
		sb(7'd86, 1'b1);
		sb(7'd85, 1'b1);
		vw();
		sb(7'd87, 1'b0);
		sb(7'd100, 1'b0);
		sb(7'd1, 1'b0);
		sb(7'd63, 1'b0);
		fw(2'd2, 1'b0);
		fw(2'd3, 1'b0);
	endtask : t_single
	task automatic t_pers();
		pb(2'd0, 32'h8000_0001, 1'b1);
		pb(2'd1, 32'h0000_0100, 1'b1);
		pb(2'd3, 32'h0000_0001, 1'b0);
		vw();
		pb(2'd0, 32'h0000_0002, 1'b1);
		sb(7'd72, 1'b0);
		fw(2'd0, 1'b1);
		pb(2'd2, 32'hFF80_0010, 1'b1);
		vw();
		pb(2'd0, 32'h0000_0004, 1'b0);
		fw(2'd2, 1'b0);
		vw();
	endtask : t_pers

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// Reset, then every scenario in turn
	initial begin
		rst_n_i = 1'b0;
		ef = {FS, FM, {88{1'b1}}};
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_id();
		t_rom();
		t_bus();
		t_single();
		t_pers();
		report_and_stop();
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_total++;
		report_and_stop();
	end
endmodule : frac_top_tb
